// *** tasx_consts.svh ***
// constants of the table access, xor and skip execution block
`ifndef TASX_CONSTS_SVH
`define TASX_CONSTS_SVH

`define TASX_TPTR_W       21
`define TASX_FADDR_W      12
`define TASX_BSR_W        4
`define TASX_HOLD_AW      6

// opcode fields, upper bits compared against the instruction word
`define TASX_OPC_TRD      14'h0002
`define TASX_OPC_TWT      14'h0003
`define TASX_OPC_TST      7'h33
`define TASX_OPC_XLW      8'h0A
`define TASX_OPC_XWF      6'h06

// pointer update field
`define TASX_PTR_KEEP     2'h0
`define TASX_PTR_POSTINC  2'h1
`define TASX_PTR_POSTDEC  2'h2
`define TASX_PTR_PREINC   2'h3

// indexed literal offset limit and access bank split
`define TASX_ILO_MAX      8'h5F
`define TASX_ACC_SPLIT    8'h80
`define TASX_ACC_HIGH     4'hF

// quarter phases per instruction cycle
`define TASX_Q_LAST       2'h3
`define TASX_Q_READ       2'h1
`define TASX_Q_PROC       2'h2

`define TASX_ACC_RST      8'h00
`define TASX_TPTR_RST     21'h000000
`define TASX_TLAT_RST     8'h00

`endif

// *** tasx_pkg.sv ***
// types of the table access, xor and skip execution block
`include "tasx_consts.svh"
package tasx_pkg;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_TBL2,
    ST_SKIP,
    ST_SKIP2
  } tasx_state_t;

  typedef struct packed {
    logic [1:0]              q;
    tasx_state_t             st;
    logic [15:0]             ir;
    logic                    two;
    logic                    is_wt;
    logic [7:0]              opnd;
    logic [7:0]              res;
    logic [`TASX_TPTR_W-1:0] tptr;
    logic [7:0]              tlat;
    logic [7:0]              acc;
    logic                    fn;
    logic                    fz;
  } tasx_core_t;

  function automatic logic tasx_is_trd(input logic [15:0] w);
    return w[15:2] == `TASX_OPC_TRD;
  endfunction : tasx_is_trd

  function automatic logic tasx_is_twt(input logic [15:0] w);
    return w[15:2] == `TASX_OPC_TWT;
  endfunction : tasx_is_twt

  function automatic logic tasx_is_tst(input logic [15:0] w);
    return w[15:9] == `TASX_OPC_TST;
  endfunction : tasx_is_tst

  function automatic logic tasx_is_xlw(input logic [15:0] w);
    return w[15:8] == `TASX_OPC_XLW;
  endfunction : tasx_is_xlw

  function automatic logic tasx_is_xwf(input logic [15:0] w);
    return w[15:10] == `TASX_OPC_XWF;
  endfunction : tasx_is_xwf

endpackage : tasx_pkg

// *** tasx_hold_mem.sv ***
// write holding registers, one byte each, registered read port
`timescale 1ns/1ps
`include "tasx_consts.svh"
module tasx_hold_mem #(
  parameter int AW = `TASX_HOLD_AW,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          clock_i,
  input  wire logic          reset_n_i,
  // write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  // read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_reg [(1<<AW)];
  logic [DW-1:0] rdata_reg;

  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= mem_reg[raddr_i];
    end
  end

  assign rdata_o = rdata_reg;

endmodule : tasx_hold_mem

// *** tasx_xor_alu.sv ***
// xor unit with negative and zero flags
`timescale 1ns/1ps
module tasx_xor_alu (
  // operands
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  // result and flags
  output logic      [7:0] res_o,
  output logic            neg_o,
  output logic            zero_o
);

  always_comb begin
    res_o  = a_i ^ b_i;
    neg_o  = res_o[7];
    zero_o = (res_o == 8'h00);
  end

endmodule : tasx_xor_alu

// *** tasx_core.sv ***
// table access, test-and-skip and xor instruction execution core
`timescale 1ns/1ps
`include "tasx_consts.svh"

// Functional notes
// - table read opcode, low two bits select pointer update mode
// - table write opcode ends 11, same two-bit pointer update field
// - table read is one word, two cycles, memory read in second
// - end of table read second cycle loads fetched byte into latch
// - table write takes two cycles, reads latch, no array programming
// - end of table write puts latch into pointer-selected holding byte
// - pointer: keep, post-inc, post-dec or pre-inc by one
// - test register zero discards fetched next instruction, runs no-op
// - test takes one, two, or three cycles if skipped word pair
// - xor literal into accumulator in one cycle, only N and Z
// - xor register, one cycle, N and Z, destination bit chooses target
// - bank bit clear uses access bank, set uses bank select
// - extended set, bank bit clear, f up to 95 is indexed
module tasx_core #(
  parameter int HOLD_AW = `TASX_HOLD_AW
) (
  // clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     reset_n_i,
  // instruction stream
  input  wire logic [15:0]              instr_i,
  input  wire logic                     instr_two_word_i,
  output logic                          instr_take_o,
  output logic                          cycle_nop_o,
  // configuration
  input  wire logic [`TASX_BSR_W-1:0]   bank_select_register_i,
  input  wire logic                     ext_set_en_i,
  input  wire logic [`TASX_FADDR_W-1:0] fsr2_i,
  // direct loads of table pointer and latch
  input  wire logic                     tptr_load_i,
  input  wire logic [`TASX_TPTR_W-1:0]  tptr_wdata_i,
  input  wire logic                     tlat_load_i,
  input  wire logic [7:0]               tlat_wdata_i,
  // data register file
  output logic      [`TASX_FADDR_W-1:0] file_addr_o,
  input  wire logic [7:0]               file_rdata_i,
  output logic                          file_we_o,
  output logic      [7:0]               file_wdata_o,
  // program memory
  output logic                          prog_rd_o,
  output logic      [`TASX_TPTR_W-1:0]  prog_addr_o,
  input  wire logic [7:0]               prog_rdata_i,
  // holding register readout
  input  wire logic [HOLD_AW-1:0]       hold_raddr_i,
  output logic      [7:0]               hold_rdata_o,
  // architectural state
  output logic      [`TASX_TPTR_W-1:0]  table_pointer_o,
  output logic      [7:0]               table_latch_o,
  output logic      [7:0]               accumulator_o,
  output logic                          flag_neg_o,
  output logic                          flag_zero_o
);

  tasx_pkg::tasx_core_t r_reg;
  tasx_pkg::tasx_core_t r_next;

  logic       q_end;
  logic       is_table;
  logic       hold_we;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  logic       alu_neg;
  logic       alu_zero;
  logic [7:0] fsel;

  function automatic logic [`TASX_FADDR_W-1:0] file_map(
    input logic [7:0]               f,
    input logic                     a,
    input logic                     ext,
    input logic [`TASX_BSR_W-1:0]   bank_select_register,
    input logic [`TASX_FADDR_W-1:0] fsr2
  );
    logic [`TASX_FADDR_W-1:0] adr;
    adr = {bank_select_register, f};
    if (!a) begin
      if (ext && f <= `TASX_ILO_MAX) begin
        adr = fsr2 + {4'h0, f};
      end else if (f >= `TASX_ACC_SPLIT) begin
        adr = {`TASX_ACC_HIGH, f};
      end else begin
        adr = {4'h0, f};
      end
    end
    return adr;
  endfunction : file_map

  assign q_end    = (r_reg.q == `TASX_Q_LAST);
  assign fsel     = r_reg.ir[7:0];
  assign is_table = tasx_pkg::tasx_is_trd(r_reg.ir)
                  | tasx_pkg::tasx_is_twt(r_reg.ir);
  // literal for immediate form, fetched register otherwise
  assign alu_b    = tasx_pkg::tasx_is_xlw(r_reg.ir) ? fsel : r_reg.opnd;

  tasx_xor_alu u_alu (
    .a_i    (r_reg.acc),
    .b_i    (alu_b),
    .res_o  (alu_res),
    .neg_o  (alu_neg),
    .zero_o (alu_zero)
  );

  // holding byte written at end of the second table write cycle
  assign hold_we = (r_reg.st == tasx_pkg::ST_TBL2) && r_reg.is_wt
                 && q_end;

  tasx_hold_mem #(
    .AW (HOLD_AW),
    .DW (8)
  ) u_hold (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .we_i      (hold_we),
    .waddr_i   (r_reg.tptr[HOLD_AW-1:0]),
    .wdata_i   (r_reg.tlat),
    .raddr_i   (hold_raddr_i),
    .rdata_o   (hold_rdata_o)
  );

  always_comb begin
    r_next   = r_reg;
    r_next.q = r_reg.q + 2'h1;
    // a new program word enters at the first quarter, except table cycle 2
    if (r_reg.q == 2'h0 && r_reg.st != tasx_pkg::ST_TBL2) begin
      r_next.ir  = instr_i;
      r_next.two = instr_two_word_i;
    end
    if (r_reg.q == `TASX_Q_READ) begin
      r_next.opnd = file_rdata_i;
    end
    if (r_reg.q == `TASX_Q_PROC) begin
      r_next.res = alu_res;
    end
    if (q_end) begin
      unique case (r_reg.st)
        tasx_pkg::ST_RUN: begin
          if (is_table) begin
            r_next.st    = tasx_pkg::ST_TBL2;
            r_next.is_wt = tasx_pkg::tasx_is_twt(r_reg.ir);
            if (r_reg.ir[1:0] == `TASX_PTR_PREINC) begin
              r_next.tptr = r_reg.tptr + 21'h000001;
            end
          end else if (tasx_pkg::tasx_is_tst(r_reg.ir)) begin
            if (r_reg.opnd == 8'h00) begin
              r_next.st = tasx_pkg::ST_SKIP;
            end
          end else if (tasx_pkg::tasx_is_xlw(r_reg.ir)) begin
            r_next.acc = alu_res;
            r_next.fn  = alu_neg;
            r_next.fz  = alu_zero;
          end else if (tasx_pkg::tasx_is_xwf(r_reg.ir)) begin
            if (!r_reg.ir[9]) begin
              r_next.acc = alu_res;
            end
            r_next.fn = alu_neg;
            r_next.fz = alu_zero;
          end
        end
        tasx_pkg::ST_TBL2: begin
          r_next.st = tasx_pkg::ST_RUN;
          if (!r_reg.is_wt) begin
            r_next.tlat = prog_rdata_i;
          end
          if (r_reg.ir[1:0] == `TASX_PTR_POSTINC) begin
            r_next.tptr = r_reg.tptr + 21'h000001;
          end else if (r_reg.ir[1:0] == `TASX_PTR_POSTDEC) begin
            r_next.tptr = r_reg.tptr - 21'h000001;
          end
        end
        tasx_pkg::ST_SKIP: begin
          // second word of a skipped pair is dropped too
          r_next.st = r_reg.two ? tasx_pkg::ST_SKIP2
                                : tasx_pkg::ST_RUN;
        end
        tasx_pkg::ST_SKIP2: begin
          r_next.st = tasx_pkg::ST_RUN;
        end
      endcase
    end
    if (tptr_load_i) begin
      r_next.tptr = tptr_wdata_i;
    end
    if (tlat_load_i) begin
      r_next.tlat = tlat_wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_reg       <= '0;
      r_reg.st    <= tasx_pkg::ST_RUN;
      r_reg.tptr  <= `TASX_TPTR_RST;
      r_reg.tlat  <= `TASX_TLAT_RST;
      r_reg.acc   <= `TASX_ACC_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign instr_take_o = (r_reg.q == 2'h0) && (r_reg.st != tasx_pkg::ST_TBL2);
  assign cycle_nop_o  = (r_reg.st == tasx_pkg::ST_SKIP)
                      || (r_reg.st == tasx_pkg::ST_SKIP2);
  assign file_addr_o  = file_map(fsel, r_reg.ir[8], ext_set_en_i,
                                 bank_select_register_i,
                                 fsr2_i);
  assign file_we_o    = (r_reg.st == tasx_pkg::ST_RUN) && q_end
                      && tasx_pkg::tasx_is_xwf(r_reg.ir)
                      && r_reg.ir[9];
  assign file_wdata_o = r_reg.res;
  assign prog_rd_o    = (r_reg.st == tasx_pkg::ST_TBL2)
                      && !r_reg.is_wt;
  assign prog_addr_o  = r_reg.tptr;
  assign table_pointer_o = r_reg.tptr;
  assign table_latch_o   = r_reg.tlat;
  assign accumulator_o   = r_reg.acc;
  assign flag_neg_o      = r_reg.fn;
  assign flag_zero_o     = r_reg.fz;

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  logic run_end;
  assign run_end = (r_reg.st == tasx_pkg::ST_RUN) && q_end;

  sequence s_tbl_second;
    (r_reg.st == tasx_pkg::ST_TBL2) [*4] ##1
    (r_reg.st == tasx_pkg::ST_RUN);
  endsequence

  sequence s_skip_one;
    (r_reg.st == tasx_pkg::ST_SKIP) [*4];
  endsequence

  AST_TBL_TWO_CYCLES: assert property (
    run_end && is_table && !tptr_load_i |=> s_tbl_second)
    else $error("table op not two cycles");
  AST_LATCH_LOAD: assert property (
    (r_reg.st == tasx_pkg::ST_TBL2) && q_end && !r_reg.is_wt
    && !tlat_load_i |=> r_reg.tlat == $past(prog_rdata_i))
    else $error("latch not loaded from program memory");
  AST_TWT_NO_PROG: assert property (
    (r_reg.st == tasx_pkg::ST_TBL2) && r_reg.is_wt |-> !prog_rd_o)
    else $error("program memory read during table write");
  AST_POST_INC: assert property (
    (r_reg.st == tasx_pkg::ST_TBL2) && q_end && !tptr_load_i
    && r_reg.ir[1:0] == `TASX_PTR_POSTINC
    |=> r_reg.tptr == $past(r_reg.tptr) + 21'h000001)
    else $error("post increment wrong");
  AST_PRE_INC: assert property (
    run_end && is_table && !tptr_load_i
    && r_reg.ir[1:0] == `TASX_PTR_PREINC
    |=> r_reg.tptr == $past(r_reg.tptr) + 21'h000001)
    else $error("pre increment wrong");
  AST_SKIP_ZERO: assert property (
    run_end && tasx_pkg::tasx_is_tst(r_reg.ir) && r_reg.opnd == 8'h00
    |=> s_skip_one ##1 (r_reg.st != tasx_pkg::ST_SKIP))
    else $error("zero test did not skip one cycle");
  AST_SKIP_SINGLE: assert property (
    (r_reg.st == tasx_pkg::ST_SKIP) && q_end && !r_reg.two
    |=> r_reg.st == tasx_pkg::ST_RUN)
    else $error("one-word skip not two cycles");
  AST_NO_SKIP: assert property (
    run_end && tasx_pkg::tasx_is_tst(r_reg.ir) && r_reg.opnd != 8'h00
    |=> r_reg.st == tasx_pkg::ST_RUN)
    else $error("nonzero test skipped");
  AST_SKIP_PAIR: assert property (
    (r_reg.st == tasx_pkg::ST_SKIP) && q_end && r_reg.two
    |=> (r_reg.st == tasx_pkg::ST_SKIP2) [*4] ##1
        (r_reg.st == tasx_pkg::ST_RUN))
    else $error("two-word skip not three cycles");
  AST_XLW_RESULT: assert property (
    run_end && tasx_pkg::tasx_is_xlw(r_reg.ir)
    |=> r_reg.acc == ($past(r_reg.acc) ^ $past(r_reg.ir[7:0]))
        && r_reg.fz == (r_reg.acc == 8'h00))
    else $error("xor literal result wrong");
  AST_XWF_FILE: assert property (
    file_we_o |-> file_wdata_o == (r_reg.acc ^ r_reg.opnd)
    ##1 r_reg.acc == $past(r_reg.acc))
    else $error("xor register write wrong");
  AST_XWF_ACC: assert property (
    run_end && tasx_pkg::tasx_is_xwf(r_reg.ir) && !r_reg.ir[9]
    |=> r_reg.acc == ($past(r_reg.acc) ^ $past(r_reg.opnd)))
    else $error("xor register to accumulator wrong");
  AST_TWT_HOLD: assert property (
    hold_we |=> u_hold.mem_reg[$past(r_reg.tptr[HOLD_AW-1:0])]
                == $past(r_reg.tlat))
    else $error("holding byte not written from latch");
  AST_BANK_SEL: assert property (
    r_reg.ir[8] |-> file_addr_o == {bank_select_register_i, fsel})
    else $error("banked address wrong");
  AST_FLAGS_KEEP: assert property (
    run_end && (is_table || tasx_pkg::tasx_is_tst(r_reg.ir))
    |=> $stable(r_reg.fn) && $stable(r_reg.fz))
    else $error("flags changed by table or test op");
  AST_SKIP_SEQ: assert property (
    cycle_nop_o |-> !file_we_o && !prog_rd_o
    ##1 $stable(r_reg.acc) && $stable(r_reg.fz))
    else $error("skip cycle not a no-op");

endmodule : tasx_core

// *** tasx_mem_model.sv ***
// program memory and data register file model facing the core
`timescale 1ns/1ps
module tasx_mem_model (
  // clock
  input  wire logic        clock_i,
  // data register file
  input  wire logic [11:0] file_addr_i,
  output logic      [7:0]  file_rdata_o,
  input  wire logic        file_we_i,
  input  wire logic [7:0]  file_wdata_i,
  // program memory
  input  wire logic        prog_rd_i,
  input  wire logic [20:0] prog_addr_i,
  output logic      [7:0]  prog_rdata_o
);
  logic [7:0] fmem [0:4095];

  function automatic logic [7:0] pbyte(input logic [20:0] a);
    return a[7:0] ^ a[15:8] ^ {3'h5, a[20:16]};
  endfunction : pbyte

  initial begin
    for (int i = 0; i < 4096; i++) begin
      fmem[i] = 8'(i) ^ {4'(i >> 8), 4'(i >> 8)};
    end
  end

  always @(posedge clock_i) begin
    if (file_we_i) begin
      fmem[file_addr_i] <= file_wdata_i;
    end
  end

  assign file_rdata_o = fmem[file_addr_i];
  // not reading: bus shows inverted data
  assign prog_rdata_o = prog_rd_i ? pbyte(prog_addr_i) : ~pbyte(prog_addr_i);
endmodule : tasx_mem_model

// *** tasx_core_test.sv ***
// random and corner tests of the execution core against a memory model
`timescale 1ns/1ps
module tasx_core_test;
  logic        clk = 0, rst_n = 0, two = 0, tpl = 0, tll = 0, ext = 0;
  logic [15:0] ins = 16'h0000, w;
  logic [3:0]  bank_select_register = 4'h0;
  logic [11:0] fsr2 = 12'h000, fa_o, wr_a;
  logic [20:0] tpw = 21'h000000, e_tp = 21'h000000, tp, pa, rd_a, ax;
  logic [7:0]  tlw = 8'h00, e_acc = 8'h00, e_lat = 8'h00, v;
  logic [7:0]  prd, frd, fwd, hrd, tl, acc, wr_d;
  logic [5:0]  hra = 6'h00, ha = 6'h00;
  logic        take, nop, fwe, prd_en, fn, fz, e_n = 0, e_z = 0;
  logic [1:0]  qb;
  int bad_count = 0, cmp_count = 0, seed = 30;
  int n_nop = 0, n_take = 0, n_rd = 0, n_we = 0, dn, dt, dr, dw;

  tasx_core #(.HOLD_AW(6)) tasx_core_i (
    .clock_i(clk), .reset_n_i(rst_n), .instr_i(ins),
    .instr_two_word_i(two), .instr_take_o(take), .cycle_nop_o(nop),
    .bank_select_register_i(bank_select_register), .ext_set_en_i(ext), .fsr2_i(fsr2),
    .tptr_load_i(tpl), .tptr_wdata_i(tpw), .tlat_load_i(tll),
    .tlat_wdata_i(tlw), .file_addr_o(fa_o), .file_rdata_i(frd),
    .file_we_o(fwe), .file_wdata_o(fwd), .prog_rd_o(prd_en),
    .prog_addr_o(pa), .prog_rdata_i(prd), .hold_raddr_i(hra),
    .hold_rdata_o(hrd), .table_pointer_o(tp), .table_latch_o(tl),
    .accumulator_o(acc), .flag_neg_o(fn), .flag_zero_o(fz)
  );

  tasx_mem_model tasx_mem_model_i (
    .clock_i(clk), .file_addr_i(fa_o), .file_rdata_o(frd),
    .file_we_i(fwe), .file_wdata_i(fwd), .prog_rd_i(prd_en),
    .prog_addr_i(pa), .prog_rdata_o(prd)
  );

  always #12.5 clk = ~clk;

  // quarter phase as the core counts it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qb <= 2'h0;
    end else begin
      qb <= qb + 2'h1;
    end
  end

  always @(posedge clk) begin
    n_nop <= n_nop + int'(nop === 1'b1);
    n_take <= n_take + int'(take === 1'b1);
    n_rd <= n_rd + int'(prd_en === 1'b1);
    n_we <= n_we + int'(fwe === 1'b1);
    if (prd_en === 1'b1) begin
      rd_a <= pa;
    end
    if (fwe === 1'b1) begin
      wr_a <= fa_o;
      wr_d <= fwd;
    end
  end

  task automatic chk(input string s, input logic [20:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk

  function automatic logic [11:0] fadr(input logic [7:0] f, input logic a);
    if (!a && ext && f <= 8'h5F) return fsr2 + {4'h0, f};
    if (!a) return f >= 8'h80 ? {4'hF, f} : {4'h0, f};
    return {bank_select_register, f};
  endfunction : fadr

  task automatic ld(input logic [20:0] p, input logic [7:0] l);
    @(posedge clk);
    tpl <= 1'b1;
    tll <= 1'b1;
    tpw <= p;
    tlw <= l;
    ext <= 1'($random(seed));
    bank_select_register <= 4'($random(seed));
    fsr2 <= 12'($random(seed));
    @(posedge clk);
    tpl <= 1'b0;
    tll <= 1'b0;
    e_tp = p;
    e_lat = l;
  endtask : ld

  // word offered at cycle start, follower word held after the take
  task automatic run(input logic [15:0] w, input int n,
                     input logic [15:0] w2, input logic t2);
    int c0, c1, c2, c3;
    do @(posedge clk); while (qb != 2'h3);
    ins <= w;
    hra <= ha;
    @(posedge clk);
    c0 = n_nop;
    c1 = n_take;
    c2 = n_rd;
    c3 = n_we;
    ins <= w2;
    two <= t2;
    repeat (4 * n - 1) @(posedge clk);
    ins <= 16'h0000;
    two <= 1'b0;
    // counts end at the commit edge, before the next take
    @(negedge clk);
    dn = n_nop - c0;
    dt = n_take - c1;
    dr = n_rd - c2;
    dw = n_we - c3;
    // one more cycle lets the registered holding readout settle
    @(negedge clk);
  endtask : run

  task automatic exe(input logic [15:0] w, input logic [15:0] w2 = 16'h0000,
                     input logic t2 = 1'b0);
    logic [11:0] fa;
    logic [7:0]  r, fv;
    logic        tb, xo;
    int          n, en, er, ew;
    fa = fadr(w[7:0], w[8]);
    fv = tasx_mem_model_i.fmem[fa];
    r = e_acc ^ (w[12] ? fv : w[7:0]);
    n = 1;
    en = 0;
    er = 0;
    ew = 0;
    tb = w[15:3] == 13'h0001;
    xo = w[15:8] == 8'h0A || w[15:10] == 6'h06;
    if (tb) begin
      ax = e_tp + 21'(w[1:0] == 2'h3);
      ha = ax[5:0];
      n = 2;
      if (!w[2]) begin
        e_lat = tasx_mem_model_i.pbyte(ax);
        er = 4;
      end
      e_tp = ax + 21'(w[1:0] == 2'h1) - 21'(w[1:0] == 2'h2);
    end else if (w[15:9] == 7'h33 && fv == 8'h00) begin
      n = t2 ? 3 : 2;
      en = 4 * n - 4;
    end else if (xo) begin
      e_n = r[7];
      e_z = r == 8'h00;
      ew = w[12] & w[9];
      if (ew == 0) e_acc = r;
    end
    run(w, n, w2, t2);
    chk("acc", acc, e_acc);
    chk("flag n", fn, e_n);
    chk("flag z", fz, e_z);
    chk("pointer", tp, e_tp);
    chk("latch", tl, e_lat);
    chk("nop", dn, en);
    chk("take", dt, tb ? 1 : n);
    chk("read", dr, er);
    chk("write", dw, ew);
    if (er != 0) chk("read addr", rd_a, ax);
    if (tb && w[2]) chk("hold", hrd, e_lat);
    if (ew != 0) chk("file addr", wr_a, fa);
    if (ew != 0) chk("file data", wr_d, r);
  endtask : exe

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  initial begin
    #400000;
    bad_count++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("reset acc", acc, 0);
    chk("reset pointer", tp, 0);
    chk("reset latch", tl, 0);
    // zero a register, then skip over one and two words
    v = tasx_mem_model_i.fmem[fadr(8'h12, 1'b1)];
    exe({8'h0A, v});
    exe(16'h1B12);
    exe(16'h6712, 16'h0AFF);
    exe(16'h6712, 16'h0AFF, 1'b1);
    exe(16'hFFFF);
    // pointer wrap at both ends
    ld(21'h1FFFFF, 8'hC3);
    exe(16'h000B);
    ld(21'h000000, 8'h3C);
    exe(16'h000E);
    repeat (150) begin
      w = 16'($random(seed));
      if (w[15]) ld(21'($random(seed)), 8'($random(seed)));
      case (w[14:12])
        3'h0, 3'h1: w = {13'h0001, w[2:0]};
        3'h2: w = {7'h33, w[8:0]};
        3'h3: w = {8'h0A, w[7:0]};
        default: w = {6'h06, w[9:0]};
      endcase
      exe(w, 16'($random(seed)), 1'($random(seed)));
    end
    test_done();
  end
endmodule : tasx_core_test
